/* src/rps_path_regs.sv */
// receive/transmit path selection register bank with its steering logic
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Behaviour
// - aux source 0000 tri-states pin, 0001 drives low, 0010 drives high.
// - aux source 0011 routes the chosen internal test bus bit.
// - aux source 0100 carries encoder envelope, 0101 the pre-encoder bit stream.
// - aux source 0111 carries decoded receive stream; 0110, 1000-1111 reserved.
// - uart input 00 is constant low, 01 aux input Manchester with subcarrier.
// - uart input 10 (default) analog demod, 11 aux input NRZ above 106 kBd.
// - after transmit, receiver ignores input for guard-delay bit clocks.
// - plain receive skips the guard delay; all other commands apply it.
// - guard counter also starts when an external RF field switches on.
// - decoder ignores inputs weaker than the minimum strength field.
// - collision flagged only when weaker half-bit reaches collision threshold.
// - unfixed channel: 00 stronger channel, 01 stronger and held; 10/11 reserved.
// - fixed channel: policy low bit 0 uses I, 1 uses Q.
// - even mode 0: timer tick period is twice divider plus one.
// - newer version, even mode 1: tick period is twice divider plus two.
// - receive time constant 00 freezes the PLL during reception.
// - locations 1Ah and 1Bh have no function and read 00h.
module rps_path_regs #(
  parameter int ADDR_W = 8,
  parameter bit HAS_EVEN_DIVIDER = 1'b1,
  parameter int TEST_BUS_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // internal signal sources for the aux output
  input wire logic [TEST_BUS_W-1:0] test_bus,
  input wire logic encoder_envelope,
  input wire logic tx_serial_bits,
  input wire logic rx_decoded_bits,
  // aux serial pins
  input wire logic aux_serial_input_pin,
  output logic aux_serial_output_pin_o,
  output logic aux_serial_output_pin_oe,
  // receive front
  input wire logic analog_demod_in,
  input wire logic rf_field_detect,
  input wire logic tx_done,
  input wire logic receive_only_cmd,
  input wire logic bit_clock_tick,
  output logic uart_rx_in,
  output logic rx_guard_active,
  // decoder levels
  input wire logic [3:0] decoder_strength,
  input wire logic [2:0] weak_half_strength,
  output logic decoder_accept,
  output logic bit_collision,
  // channel choice
  input wire logic [7:0] i_strength,
  input wire logic [7:0] q_strength,
  input wire logic comm_active,
  output logic use_q_channel,
  // pll and timer
  input wire logic rx_active,
  output logic pll_frozen,
  output logic [1:0] pll_time_constant,
  output logic timer_tick
);
  import rps_pkg::*;

  if (ADDR_W < 8) begin : g_chk_addr
    $error("ADDR_W must be at least 8");
  end
  if (TEST_BUS_W != 8) begin : g_chk_bus
    $error("TEST_BUS_W must be 8 to match the 3-bit bit choice");
  end
  typedef struct packed {
    logic aw_held;
    logic [5:0] aw_idx;
    logic aw_ok, w_held;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [11:0] rdata;
    logic [1:0] rresp;
    logic [7:0] rx_path, thresh, demod, tx_src;
    logic [2:0] test_sel;
    logic [11:0] timer_div;
    logic [1:0] aux_sync, rf_sync;
    logic rf_prev;
    logic [5:0] guard_cnt;
    logic aux_out, aux_oe, uart_in, dec_accept, coll, use_q, frozen_q, comm_prev;
    logic [12:0] div_cnt;
    logic tick;
  } rps_state_type;
  localparam rps_state_type RPS_RESET_ST = '{
    aw_held: 1'b0, aw_idx: 6'h00, aw_ok: 1'b0, w_held: 1'b0, w_data: 16'h0000,
    w_strb: 2'h0, bvalid: 1'b0, bresp: RPS_RESP_OKAY, rvalid: 1'b0,
    rdata: 12'h000, rresp: RPS_RESP_OKAY, rx_path: RPS_RST_RX_PATH,
    thresh: RPS_RST_THRESH, demod: RPS_RST_DEMOD, tx_src: RPS_RST_TX_SOURCE,
    test_sel: RPS_RST_TEST_SEL, timer_div: RPS_RST_TIMER_DIV, aux_sync: 2'h0,
    rf_sync: 2'h0, rf_prev: 1'b0, guard_cnt: 6'h00, aux_out: 1'b0,
    aux_oe: 1'b0, uart_in: 1'b0, dec_accept: 1'b0, coll: 1'b0, use_q: 1'b0,
    frozen_q: 1'b0, comm_prev: 1'b0, div_cnt: 13'h0000, tick: 1'b0
  };

  rps_state_type st_r, st_nxt;
  logic take_aw, take_w, take_ar, ar_ok, aw_ok_in, fixed_ch, even_mode, q_stronger, rf_on_edge;
  logic [5:0] ar_idx, aw_idx_in, wr_idx;
  logic [15:0] wr_data;
  logic [1:0] wr_strb, uart_sel, iq_policy, tau_rcv, tau_burst;
  logic [3:0] aux_src;
  logic [13:0] div_period;

  // only the low word lanes carry register bits, upper byte bits read as zero
  assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = {20'h00000, st_r.rdata};
  assign take_aw = s_axi_awvalid && s_axi_awready;
  assign take_w = s_axi_wvalid && s_axi_wready;
  assign take_ar = s_axi_arvalid && s_axi_arready;
  assign aw_idx_in = s_axi_awaddr[7:2];
  assign ar_idx = s_axi_araddr[7:2];
  // upper address bits and byte offset must be zero to hit the bank
  assign aw_ok_in = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr >> 8 == '0);
  assign ar_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr >> 8 == '0);
  assign wr_idx = st_r.aw_held ? st_r.aw_idx : aw_idx_in;
  assign wr_data = st_r.w_held ? st_r.w_data : s_axi_wdata[15:0];
  assign wr_strb = st_r.w_held ? st_r.w_strb : s_axi_wstrb[1:0];
  assign aux_src = st_r.tx_src[RPS_POS_AUX_SRC +: 4];
  assign uart_sel = st_r.rx_path[RPS_POS_UART_SEL +: 2];
  assign iq_policy = st_r.demod[RPS_POS_IQ_POLICY +: 2];
  assign fixed_ch = st_r.demod[RPS_POS_FIXED_CH];
  // older silicon has only the odd divider
  assign even_mode = HAS_EVEN_DIVIDER && st_r.demod[RPS_POS_EVEN_MODE];
  assign tau_rcv = st_r.demod[RPS_POS_TAU_RCV +: 2];
  assign tau_burst = st_r.demod[RPS_POS_TAU_BURST +: 2];
  // one spare bit so the longest even period does not wrap to zero
  assign div_period = {1'b0, st_r.timer_div, 1'b0} + (even_mode ? 14'h0002 : 14'h0001);
  assign q_stronger = q_strength > i_strength;
  assign rf_on_edge = st_r.rf_sync[1] && !st_r.rf_prev;

  always_comb
  begin
    st_nxt = st_r;
    // write path: address and data may arrive in either order
    if (take_aw)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_idx = aw_idx_in;
      st_nxt.aw_ok = aw_ok_in;
    end
    if (take_w)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata[15:0];
      st_nxt.w_strb = s_axi_wstrb[1:0];
    end
    if ((st_r.aw_held || take_aw) && (st_r.w_held || take_w))
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RPS_RESP_OKAY;
      if (!(st_r.aw_held ? st_r.aw_ok : aw_ok_in))
      begin
        st_nxt.bresp = RPS_RESP_SLVERR;
      end
      else if (wr_strb[0])
      begin
        unique case (wr_idx)
          RPS_IDX_TX_SOURCE: st_nxt.tx_src = wr_data[7:0] & RPS_MASK_TX_SOURCE;
          RPS_IDX_RX_PATH: st_nxt.rx_path = wr_data[7:0];
          RPS_IDX_THRESH: st_nxt.thresh = wr_data[7:0] & RPS_MASK_THRESH;
          RPS_IDX_DEMOD: st_nxt.demod = wr_data[7:0];
          RPS_IDX_TEST_SEL: st_nxt.test_sel = wr_data[2:0];
          RPS_IDX_TIMER_DIV: st_nxt.timer_div[7:0] = wr_data[7:0];
          RPS_IDX_RSVD_A, RPS_IDX_RSVD_B: st_nxt.bresp = RPS_RESP_OKAY;
          default: st_nxt.bresp = RPS_RESP_SLVERR;
        endcase
      end
      if (wr_strb[1] && wr_idx == RPS_IDX_TIMER_DIV && st_nxt.bresp == RPS_RESP_OKAY)
      begin
        st_nxt.timer_div[11:8] = wr_data[11:8];
      end
    end
    else if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end

    // read path
    if (take_ar)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RPS_RESP_OKAY;
      st_nxt.rdata = 12'h000;
      if (!ar_ok)
      begin
        st_nxt.rresp = RPS_RESP_SLVERR;
      end
      else
      begin
        unique case (ar_idx)
          RPS_IDX_TX_SOURCE: st_nxt.rdata = {4'h0, st_r.tx_src};
          RPS_IDX_RX_PATH: st_nxt.rdata = {4'h0, st_r.rx_path};
          RPS_IDX_THRESH: st_nxt.rdata = {4'h0, st_r.thresh};
          RPS_IDX_DEMOD: st_nxt.rdata = {4'h0, st_r.demod};
          RPS_IDX_TEST_SEL: st_nxt.rdata = {9'h000, st_r.test_sel};
          RPS_IDX_TIMER_DIV: st_nxt.rdata = st_r.timer_div;
          RPS_IDX_RSVD_A, RPS_IDX_RSVD_B: st_nxt.rdata = {4'h0, RPS_RST_RSVD};
          default: st_nxt.rresp = RPS_RESP_SLVERR;
        endcase
      end
    end
    else if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    // pin synchronisers
    st_nxt.aux_sync = {st_r.aux_sync[0], aux_serial_input_pin};
    st_nxt.rf_sync = {st_r.rf_sync[0], rf_field_detect};
    st_nxt.rf_prev = st_r.rf_sync[1];
    // aux output mux; reserved codes leave the pin floating
    st_nxt.aux_oe = 1'b1;
    st_nxt.aux_out = 1'b0;
    unique case (aux_src)
      RPS_AUX_HIZ: st_nxt.aux_oe = 1'b0;
      RPS_AUX_LOW: st_nxt.aux_out = 1'b0;
      RPS_AUX_HIGH: st_nxt.aux_out = 1'b1;
      RPS_AUX_TEST_BUS: st_nxt.aux_out = test_bus[st_r.test_sel];
      RPS_AUX_ENVELOPE: st_nxt.aux_out = encoder_envelope;
      RPS_AUX_TX_BITS: st_nxt.aux_out = tx_serial_bits;
      RPS_AUX_RX_BITS: st_nxt.aux_out = rx_decoded_bits;
      default: st_nxt.aux_oe = 1'b0;
    endcase
    if (st_r.guard_cnt != 6'h00 && bit_clock_tick)
    begin
      st_nxt.guard_cnt = st_r.guard_cnt - 6'h01;
    end
    if (tx_done && !receive_only_cmd)
    begin
      st_nxt.guard_cnt = st_r.rx_path[RPS_POS_GUARD +: 6];
    end
    if (rf_on_edge)
    begin
      st_nxt.guard_cnt = st_r.rx_path[RPS_POS_GUARD +: 6];
    end
    // uart input select, forced low while guarding
    unique case (uart_sel)
      RPS_UART_LOW: st_nxt.uart_in = 1'b0;
      RPS_UART_AUX_MANCH: st_nxt.uart_in = st_r.aux_sync[1];
      RPS_UART_ANALOG: st_nxt.uart_in = analog_demod_in;
      RPS_UART_AUX_NRZ: st_nxt.uart_in = st_r.aux_sync[1];
    endcase
    if (st_r.guard_cnt != 6'h00)
    begin
      st_nxt.uart_in = 1'b0;
    end
    st_nxt.dec_accept = decoder_strength >= st_r.thresh[RPS_POS_MIN_LEVEL +: 4];
    st_nxt.coll = st_nxt.dec_accept
      && (weak_half_strength >= st_r.thresh[RPS_POS_COLL_LEVEL +: 3]);
    // channel choice; freeze captures the choice as communication starts
    st_nxt.comm_prev = comm_active;
    if (comm_active && !st_r.comm_prev)
    begin
      st_nxt.frozen_q = q_stronger;
    end
    if (fixed_ch)
    begin
      st_nxt.use_q = iq_policy[0];
    end
    else
    begin
      // stronger or held; reserved codes keep the last choice
      unique case (iq_policy)
        RPS_IQ_STRONGER: st_nxt.use_q = q_stronger;
        RPS_IQ_FREEZE: st_nxt.use_q = comm_active
          ? (st_r.comm_prev ? st_r.frozen_q : q_stronger) : q_stronger;
        default: st_nxt.use_q = st_r.use_q;
      endcase
    end
    st_nxt.tick = 1'b0;
    if ({1'b0, st_r.div_cnt} + 14'h0001 >= div_period)
    begin
      st_nxt.div_cnt = 13'h0000;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.div_cnt = st_r.div_cnt + 13'h0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= RPS_RESET_ST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign aux_serial_output_pin_o = st_r.aux_out;
  assign aux_serial_output_pin_oe = st_r.aux_oe;
  assign uart_rx_in = st_r.uart_in;
  assign rx_guard_active = st_r.guard_cnt != 6'h00;
  assign decoder_accept = st_r.dec_accept;
  assign bit_collision = st_r.coll;
  assign use_q_channel = st_r.use_q;
  assign pll_frozen = rx_active && (tau_rcv == 2'h0);
  assign pll_time_constant = rx_active ? tau_rcv : tau_burst;
  assign timer_tick = st_r.tick;

endmodule

/* src/rps_pkg.sv */
// register map, field layout and reset values for the receive-path config bank
package rps_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] RPS_IDX_TX_SOURCE = 6'h16;
  localparam logic [5:0] RPS_IDX_RX_PATH = 6'h17;
  localparam logic [5:0] RPS_IDX_THRESH = 6'h18;
  localparam logic [5:0] RPS_IDX_DEMOD = 6'h19;
  localparam logic [5:0] RPS_IDX_RSVD_A = 6'h1a;
  localparam logic [5:0] RPS_IDX_RSVD_B = 6'h1b;
  localparam logic [5:0] RPS_IDX_TEST_SEL = 6'h30;
  localparam logic [5:0] RPS_IDX_TIMER_DIV = 6'h31;

  // reset values
  localparam logic [7:0] RPS_RST_TX_SOURCE = 8'h10;
  localparam logic [7:0] RPS_RST_RX_PATH = 8'h84;
  localparam logic [7:0] RPS_RST_THRESH = 8'h84;
  localparam logic [7:0] RPS_RST_DEMOD = 8'h4d;
  localparam logic [7:0] RPS_RST_RSVD = 8'h00;
  localparam logic [2:0] RPS_RST_TEST_SEL = 3'h0;
  localparam logic [11:0] RPS_RST_TIMER_DIV = 12'h000;

  // writable bit masks; all other bits read zero
  localparam logic [7:0] RPS_MASK_TX_SOURCE = 8'h3f;
  localparam logic [7:0] RPS_MASK_THRESH = 8'hf7;

  // field positions
  localparam int RPS_POS_AUX_SRC = 0;
  localparam int RPS_POS_UART_SEL = 6;
  localparam int RPS_POS_GUARD = 0;
  localparam int RPS_POS_MIN_LEVEL = 4;
  localparam int RPS_POS_COLL_LEVEL = 0;
  localparam int RPS_POS_IQ_POLICY = 6;
  localparam int RPS_POS_FIXED_CH = 5;
  localparam int RPS_POS_EVEN_MODE = 4;
  localparam int RPS_POS_TAU_RCV = 2;
  localparam int RPS_POS_TAU_BURST = 0;

  // aux output source codes
  localparam logic [3:0] RPS_AUX_HIZ = 4'h0;
  localparam logic [3:0] RPS_AUX_LOW = 4'h1;
  localparam logic [3:0] RPS_AUX_HIGH = 4'h2;
  localparam logic [3:0] RPS_AUX_TEST_BUS = 4'h3;
  localparam logic [3:0] RPS_AUX_ENVELOPE = 4'h4;
  localparam logic [3:0] RPS_AUX_TX_BITS = 4'h5;
  localparam logic [3:0] RPS_AUX_RX_BITS = 4'h7;

  // uart input codes
  localparam logic [1:0] RPS_UART_LOW = 2'h0;
  localparam logic [1:0] RPS_UART_AUX_MANCH = 2'h1;
  localparam logic [1:0] RPS_UART_ANALOG = 2'h2;
  localparam logic [1:0] RPS_UART_AUX_NRZ = 2'h3;

  // channel policy codes
  localparam logic [1:0] RPS_IQ_STRONGER = 2'h0;
  localparam logic [1:0] RPS_IQ_FREEZE = 2'h1;

  // bus responses
  localparam logic [1:0] RPS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RPS_RESP_SLVERR = 2'h2;

endpackage

/* dv/rps_path_regs_sva.sv */
// port-level assertion checker for the receive-path config bank
`timescale 1ns/1ps
module rps_path_regs_sva
  import rps_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // receive path
  input wire logic uart_rx_in,
  input wire logic rx_guard_active,
  input wire logic decoder_accept,
  input wire logic bit_collision,
  input wire logic rx_active,
  input wire logic pll_frozen,
  input wire logic [1:0] pll_time_constant
);
  import rps_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_guard_mutes_uart:
    assert property (rx_guard_active |=> !uart_rx_in)
    else $error("uart input not muted during guard time");
  a_coll_needs_accept:
    assert property (bit_collision |-> decoder_accept)
    else $error("collision flagged on a rejected input");
  a_pll_freeze_rx:
    assert property (pll_frozen == (rx_active && pll_time_constant == 2'h0))
    else $error("pll freeze does not follow receive time constant");
  a_rsvd_reads_zero:
    assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr == {RPS_IDX_RSVD_A, 2'b00}
      || s_axi_araddr == {RPS_IDX_RSVD_B, 2'b00})
      |=> s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == RPS_RESP_OKAY)
    else $error("reserved location read not zero and okay");
  a_upper_bits_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0)
    else $error("unused read data bits not zero");
  a_misaligned_err:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'b00
      |=> s_axi_rvalid && s_axi_rresp == RPS_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("misaligned read not refused");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid)
    else $error("write answer late");
  a_read_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_write_blocked:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule

bind rps_path_regs rps_path_regs_sva #(.ADDR_W(ADDR_W)) rps_path_regs_sva_i (.*);

/* dv/rps_path_regs_bench.sv */
// self-checking bench for the receive-path config bank
`timescale 1ns/1ps
module rps_path_regs_bench;
  import rps_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, test_bus = 8'h0;
  logic [7:0] i_strength = 8'h0, q_strength = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, weak_half_strength = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, decoder_strength = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, pll_time_constant, rsp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, comm_active = 1'b0, rx_active = 1'b0;
  logic encoder_envelope = 1'b0, tx_serial_bits = 1'b0, rx_decoded_bits = 1'b0;
  logic aux_serial_input_pin = 1'b0, analog_demod_in = 1'b0, rf_field_detect = 1'b0;
  logic tx_done = 1'b0, receive_only_cmd = 1'b0, bit_clock_tick = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic aux_serial_output_pin_o, aux_serial_output_pin_oe, uart_rx_in, rx_guard_active;
  logic decoder_accept, bit_collision, use_q_channel, pll_frozen, timer_tick;
  int error_cnt = 0;
  int n_compared = 0;

  rps_path_regs rps_path_regs_i (.*);
  always #5 aclk = ~aclk;

  function automatic logic [7:0] ba(input logic [5:0] i);
    return {i, 2'b00};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ends at a falling edge, where outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    tb = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 50)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!tb) chk("write answer", 1, 0);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic ta, tr;
    int n;
    tr = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr && n < 50)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!tr) chk("read answer", 1, 0);
  endtask

  task automatic t_resets();
    logic [5:0] ix [6] = '{RPS_IDX_TX_SOURCE, RPS_IDX_RX_PATH, RPS_IDX_THRESH,
      RPS_IDX_DEMOD, RPS_IDX_RSVD_A, RPS_IDX_RSVD_B};
    logic [7:0] ex [6] = '{8'h10, 8'h84, 8'h84, 8'h4d, 8'h00, 8'h00};
    cyc(1);
    chk("aux oe at reset", 0, aux_serial_output_pin_oe);
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(ba(ix[i]));
      chk("reset value", ex[i], rd);
    end
    $display("test reset values done");
  endtask
  task automatic t_aux();
    logic e;
    wr(ba(RPS_IDX_TEST_SEL), 32'h5);
    for (int c = 0; c < 16; c++)
    begin
      wr(ba(RPS_IDX_TX_SOURCE), 32'(c));
      for (int k = 0; k < 4; k++)
      begin
        @(posedge aclk);
        // bit 5 differs from every other test bus bit
        test_bus <= k[0] ? 8'h20 : 8'hdf;
        encoder_envelope <= k[1];
        tx_serial_bits <= k[0] ^ k[1];
        rx_decoded_bits <= ~k[0];
        cyc(3);
        e = (c == 3) ? k[0] : (c == 4) ? k[1] : (c == 5) ? k[0] ^ k[1] : ~k[0];
        if (c == 1 || c == 2) e = c[1];
        chk("aux oe", (c > 0 && c < 6) || c == 7, aux_serial_output_pin_oe);
        if ((c > 0 && c < 6) || c == 7) chk("aux level", e, aux_serial_output_pin_o);
      end
    end
    $display("test aux output done");
  endtask
  task automatic t_uart();
    for (int s = 0; s < 4; s++)
    begin
      wr(ba(RPS_IDX_RX_PATH), 32'(s << 6));
      rd_reg(ba(RPS_IDX_RX_PATH));
      chk("rx path readback", s << 6, rd);
      for (int p = 0; p < 2; p++)
      begin
        @(posedge aclk);
        aux_serial_input_pin <= p[0];
        analog_demod_in <= ~p[0];
        cyc(5);
        chk("uart input", s == 0 ? 1'b0 : s == 2 ? !p[0] : p[0], uart_rx_in);
      end
    end
    $display("test uart select done");
  endtask
  task automatic t_guard();
    wr(ba(RPS_IDX_RX_PATH), 32'h83);
    for (int m = 0; m < 3; m++)
    begin
      @(posedge aclk);
      analog_demod_in <= 1'b1;
      receive_only_cmd <= (m == 1);
      tx_done <= (m != 2);
      rf_field_detect <= (m == 2);
      @(posedge aclk);
      tx_done <= 1'b0;
      cyc(5);
      chk("guard start", m != 1, rx_guard_active);
      for (int t = 0; t < 3; t++)
      begin
        @(posedge aclk);
        bit_clock_tick <= 1'b1;
        @(posedge aclk);
        bit_clock_tick <= 1'b0;
        cyc(1);
        chk("guard count", m != 1 && t < 2, rx_guard_active);
      end
      cyc(2);
      chk("uart after guard", 1, uart_rx_in);
      @(posedge aclk);
      rf_field_detect <= 1'b0;
    end
    $display("test guard delay done");
  endtask
  task automatic t_thresh();
    wr(ba(RPS_IDX_THRESH), 32'hff);
    rd_reg(ba(RPS_IDX_THRESH));
    chk("threshold readback", 32'hf7, rd);
    wr(ba(RPS_IDX_THRESH), 32'h84);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge aclk);
      decoder_strength <= s[1] ? 4'h8 : 4'h7;
      weak_half_strength <= s[0] ? 3'h4 : 3'h3;
      cyc(2);
      chk("decoder accept", s[1], decoder_accept);
      chk("collision", s == 3, bit_collision);
    end
    $display("test thresholds done");
  endtask
  task automatic t_chan();
    logic [7:0] v [4] = '{8'h2d, 8'h6d, 8'h0d, 8'h4d};
    logic [1:0] e [4] = '{2'b00, 2'b11, 2'b10, 2'b11};
    for (int m = 0; m < 4; m++)
    begin
      wr(ba(RPS_IDX_DEMOD), 32'(v[m]));
      @(posedge aclk);
      i_strength <= 8'h0a;
      q_strength <= 8'h14;
      comm_active <= 1'b1;
      cyc(3);
      chk("channel q stronger", e[m][1], use_q_channel);
      @(posedge aclk);
      q_strength <= 8'h05;
      cyc(3);
      chk("channel q weaker", e[m][0], use_q_channel);
      @(posedge aclk);
      comm_active <= 1'b0;
    end
    $display("test channel policy done");
  endtask
  task automatic t_timer();
    int c;
    wr(ba(RPS_IDX_TIMER_DIV), 32'h2);
    for (int m = 0; m < 2; m++)
    begin
      wr(ba(RPS_IDX_DEMOD), m ? 32'h5d : 32'h4d);
      c = 0;
      cyc(1);
      while (!timer_tick && c < 20)
      begin
        cyc(1);
        c++;
      end
      c = 0;
      do
      begin
        cyc(1);
        c++;
      end while (!timer_tick && c < 20);
      chk("tick period", 5 + m, c);
    end
    wr(ba(RPS_IDX_DEMOD), 32'h41);
    @(posedge aclk);
    rx_active <= 1'b1;
    cyc(1);
    chk("pll frozen", 1, pll_frozen);
    chk("pll receive constant", 0, pll_time_constant);
    @(posedge aclk);
    rx_active <= 1'b0;
    cyc(1);
    chk("pll running", 0, pll_frozen);
    chk("pll burst constant", 1, pll_time_constant);
    $display("test timer and pll done");
  endtask
  task automatic t_bus();
    wr(ba(RPS_IDX_RSVD_A), 32'hff);
    chk("reserved write resp", RPS_RESP_OKAY, rsp);
    rd_reg(ba(RPS_IDX_RSVD_A));
    chk("reserved read", 0, rd);
    wr(8'h80, 32'hff);
    chk("unmapped write resp", RPS_RESP_SLVERR, rsp);
    rd_reg(8'h5d);
    chk("misaligned read resp", RPS_RESP_SLVERR, rsp);
    $display("test bus errors done");
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // whole run is several hundred cycles
  initial
  begin
    #200000;
    chk("watchdog", 0, 1);
    conclude();
  end
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_resets();
    t_aux();
    t_uart();
    t_guard();
    t_thresh();
    t_chan();
    t_timer();
    t_bus();
    conclude();
  end
endmodule
